// >>> tcmc_far_side.sv
module tcmc_far_side (
  input  wire logic sys_clk_in,
  output logic      pin_ch0_out,
  output logic      pin_ch3_out,
  output logic      master_int_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------------
  // Timer input pins and master channel interrupt
  // ------------------------------------------------------------------
  initial begin
    pin_ch0_out    = 1'b0;
    pin_ch3_out    = 1'b0;
    master_int_out = 1'b0;
  end

  // Pins change just after an edge; the hold of four cycles covers the
  // two synchroniser stages and the edge register behind them.
  task automatic set_pin(input logic ch, input logic lvl);
    @(posedge sys_clk_in);
    if (ch) begin
      pin_ch3_out <= lvl;
    end else begin
      pin_ch0_out <= lvl;
    end
    repeat (4) @(posedge sys_clk_in);
  endtask : set_pin

  // One-cycle interrupt pulse of the master channel.
  task automatic pulse_master();
    @(posedge sys_clk_in);
    master_int_out <= 1'b1;
    @(posedge sys_clk_in);
    master_int_out <= 1'b0;
  endtask : pulse_master
endmodule : tcmc_far_side

// >>> tcmc_params.svh
`ifndef TCMC_PARAMS_SVH
`define TCMC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TCMC_OFF_MODE0     8'h00
`define TCMC_OFF_MODE3     8'h04
`define TCMC_OFF_DATA0     8'h08
`define TCMC_OFF_DATA3     8'h0c
`define TCMC_OFF_IRQ_STS   8'h10
`define TCMC_OFF_IRQ_MASK  8'h14
`define TCMC_OFF_START     8'h18
`define TCMC_OFF_STOP      8'h1c
`define TCMC_OFF_CNT0      8'h20
`define TCMC_OFF_CNT3      8'h24

// ----------------------------------------------------------------------
// Mode register field positions
// ----------------------------------------------------------------------
`define TCMC_CKS_HI        15
`define TCMC_CKS_LO        14
`define TCMC_CCS_BIT       12
`define TCMC_SPLIT_BIT     11
`define TCMC_STS_HI        10
`define TCMC_STS_LO        8
`define TCMC_CIS_BIT       6
`define TCMC_MD_HI         3

// ----------------------------------------------------------------------
// Reset values, write masks and trigger codes
// ----------------------------------------------------------------------
`define TCMC_MODE_RESET    16'h0000
`define TCMC_MODE0_WMASK   16'hd7cf
`define TCMC_MODE3_WMASK   16'hdfcf
`define TCMC_DATA_RESET    16'hffff
`define TCMC_HALF_MASK     16'h00ff
`define TCMC_FULL_MASK     16'hffff
`define TCMC_TRG_SW        3'h0
`define TCMC_TRG_EDGE      3'h1
`define TCMC_TRG_BOTH      3'h2
`define TCMC_TRG_MASTER    3'h4

`endif

// >>> tcmc_pkg.sv
package tcmc_pkg;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic [5:0] {
    TCMC_MD_INTERVAL = 6'h01,
    TCMC_MD_CAPTURE  = 6'h02,
    TCMC_MD_EVENT    = 6'h04,
    TCMC_MD_ONECOUNT = 6'h08,
    TCMC_MD_CAPONE   = 6'h10,
    TCMC_MD_PROHIB   = 6'h20
  } tcmc_mode_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tcmc_bus_type;

endpackage : tcmc_pkg

// >>> tcmc_timer_mode.sv
`include "tcmc_params.svh"

module tcmc_timer_mode #(
  parameter int CNT_W = 16
) (
  input  wire logic                  sys_clk_in,
  input  wire logic                  nrst_in,
  input  wire tcmc_pkg::tcmc_bus_type bus_in,
  output logic [15:0]                rdata_out,
  input  wire logic [3:0]            prescaled_clk_in,
  input  wire logic                  timer_in_pin_ch0_in,
  input  wire logic                  timer_in_pin_ch3_in,
  input  wire logic                  master_int_in,
  output logic                       timer_out_ch0_out,
  output logic                       timer_out_ch3_out,
  output logic                       tint_ch0_out,
  output logic                       tint_ch3_out,
  output logic                       irq_out
);
  import tcmc_pkg::*;

  // --------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------
  if (CNT_W != 16) begin : g_bad_width
    $error("tcmc_timer_mode supports only a 16-bit counter");
  end

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  function automatic tcmc_mode_type decode_mode(input logic [3:0] md);
    if (md[3:1] == 3'h0) begin
      return TCMC_MD_INTERVAL;
    end else if (md[3:1] == 3'h2) begin
      return TCMC_MD_CAPTURE;
    end else if (md == 4'h6) begin
      return TCMC_MD_EVENT;
    end else if (md[3:1] == 3'h4) begin
      return TCMC_MD_ONECOUNT;
    end else if (md == 4'hc) begin
      return TCMC_MD_CAPONE;
    end else begin
      return TCMC_MD_PROHIB;
    end
  endfunction : decode_mode

  function automatic logic trig_legal(input logic [2:0] sel);
    return (sel == `TCMC_TRG_SW) || (sel == `TCMC_TRG_EDGE) ||
           (sel == `TCMC_TRG_BOTH) || (sel == `TCMC_TRG_MASTER);
  endfunction : trig_legal

  function automatic logic op_tick(input logic [1:0] cks,
                                   input logic [3:0] ck);
    logic t;
    t = 1'b0;
    case (cks)
      2'h0:    t = ck[0];
      2'h1:    t = ck[2];
      2'h2:    t = ck[1];
      default: t = ck[3];
    endcase
    return t;
  endfunction : op_tick

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [1:0] ti_s1_ff;
  logic [1:0] ti_s2_ff;
  logic [1:0] ti_d_ff;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ti_s1_ff <= 2'h0;
      ti_s2_ff <= 2'h0;
      ti_d_ff  <= 2'h0;
    end else begin
      ti_s1_ff <= {timer_in_pin_ch3_in, timer_in_pin_ch0_in};
      ti_s2_ff <= ti_s1_ff;
      ti_d_ff  <= ti_s2_ff;
    end
  end

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  logic [15:0]     mode_ff [2];
  logic [15:0]     data_ff [2];
  logic [15:0]     cnt_ff  [2];
  logic [1:0]      run_ff;
  logic [1:0]      tout_ff;
  logic [1:0]      tint_ff;
  logic [3:0]      sts_ff;
  logic [3:0]      mask_ff;
  logic [15:0]     rdata_ff;
  logic            irq_ff;
  logic [15:0]     nxt_mode [2];
  logic [15:0]     nxt_data [2];
  logic [15:0]     nxt_cnt  [2];
  logic [1:0]      nxt_run;
  logic [1:0]      nxt_tout;
  logic [1:0]      nxt_tint;
  logic [3:0]      nxt_sts;
  logic [3:0]      nxt_mask;
  logic [15:0]     nxt_rdata;
  logic            nxt_irq;
  tcmc_mode_type   md_v   [2];
  logic [1:0]      trig_v;
  logic [1:0]      tick_v;
  logic [1:0]      vedge_v;
  logic [1:0]      rise_v;
  logic [1:0]      fall_v;
  logic [1:0]      bad_v;
  logic [1:0]      sw_start;
  logic [1:0]      sw_stop;
  logic [3:0]      ev_set;
  logic [15:0]     wmask_v [2];

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  always_comb begin
    logic [2:0]  sel;
    logic        hw;
    logic        lowb;
    logic [15:0] reload;
    sel       = 3'h0;
    hw        = 1'b0;
    lowb      = 1'b0;
    reload    = 16'h0000;
    nxt_mode  = mode_ff;
    nxt_data  = data_ff;
    nxt_cnt   = cnt_ff;
    nxt_run   = run_ff;
    nxt_tout  = tout_ff;
    nxt_tint  = 2'h0;
    nxt_mask  = mask_ff;
    ev_set    = 4'h0;
    sw_start  = 2'h0;
    sw_stop   = 2'h0;
    if (bus_in.wr) begin
      if (bus_in.addr == `TCMC_OFF_MODE0) begin
        nxt_mode[0] = bus_in.wdata & `TCMC_MODE0_WMASK;
      end else if (bus_in.addr == `TCMC_OFF_MODE3) begin
        nxt_mode[1] = bus_in.wdata & `TCMC_MODE3_WMASK;
      end else if (bus_in.addr == `TCMC_OFF_DATA0) begin
        nxt_data[0] = bus_in.wdata;
      end else if (bus_in.addr == `TCMC_OFF_DATA3) begin
        nxt_data[1] = bus_in.wdata;
      end else if (bus_in.addr == `TCMC_OFF_IRQ_MASK) begin
        nxt_mask = bus_in.wdata[3:0];
      end else if (bus_in.addr == `TCMC_OFF_START) begin
        sw_start = bus_in.wdata[1:0];
      end else if (bus_in.addr == `TCMC_OFF_STOP) begin
        sw_stop = bus_in.wdata[1:0];
      end
    end
    for (int ch = 0; ch < 2; ch++) begin
      md_v[ch]    = decode_mode(mode_ff[ch][`TCMC_MD_HI:0]);
      lowb        = mode_ff[ch][0];
      sel         = mode_ff[ch][`TCMC_STS_HI:`TCMC_STS_LO];
      bad_v[ch]   = (md_v[ch] == TCMC_MD_PROHIB) || !trig_legal(sel);
      rise_v[ch]  = ti_s2_ff[ch] & ~ti_d_ff[ch];
      fall_v[ch]  = ~ti_s2_ff[ch] & ti_d_ff[ch];
      vedge_v[ch] = mode_ff[ch][`TCMC_CIS_BIT] ? rise_v[ch] : fall_v[ch];
      case (sel)
        `TCMC_TRG_EDGE:   hw = vedge_v[ch];
        `TCMC_TRG_BOTH:   hw = rise_v[ch] | fall_v[ch];
        `TCMC_TRG_MASTER: hw = master_int_in;
        default:          hw = 1'b0;
      endcase
      trig_v[ch] = sw_start[ch] | hw;
      tick_v[ch] = mode_ff[ch][`TCMC_CCS_BIT] ? vedge_v[ch] :
                   op_tick(mode_ff[ch][`TCMC_CKS_HI:`TCMC_CKS_LO],
                           prescaled_clk_in);
      // Only channel 3 can split; its upper byte then stays at zero.
      wmask_v[ch] = (ch == 1 && mode_ff[1][`TCMC_SPLIT_BIT]) ?
                    `TCMC_HALF_MASK : `TCMC_FULL_MASK;
      reload = data_ff[ch] & wmask_v[ch];
      ev_set[ch + 2] = bad_v[ch];
      if (bad_v[ch] || sw_stop[ch]) begin
        nxt_run[ch] = 1'b0;
      end else if (!run_ff[ch]) begin
        if (trig_v[ch]) begin
          nxt_run[ch] = 1'b1;
          if (md_v[ch] == TCMC_MD_CAPTURE || md_v[ch] == TCMC_MD_CAPONE) begin
            nxt_cnt[ch] = 16'h0000;
          end else begin
            nxt_cnt[ch] = reload;
          end
          if (lowb && (md_v[ch] == TCMC_MD_INTERVAL ||
                       md_v[ch] == TCMC_MD_CAPTURE)) begin
            nxt_tint[ch] = 1'b1;
          end
        end
      end else begin
        case (md_v[ch])
          TCMC_MD_INTERVAL, TCMC_MD_EVENT: begin
            if (tick_v[ch]) begin
              if (cnt_ff[ch] == 16'h0000) begin
                nxt_cnt[ch]  = reload;
                nxt_tint[ch] = 1'b1;
              end else begin
                nxt_cnt[ch] = (cnt_ff[ch] - 16'h0001) & wmask_v[ch];
              end
            end
          end
          TCMC_MD_CAPTURE: begin
            if (trig_v[ch]) begin
              nxt_data[ch] = cnt_ff[ch];
              nxt_cnt[ch]  = 16'h0000;
              nxt_tint[ch] = 1'b1;
            end else if (tick_v[ch]) begin
              nxt_cnt[ch] = (cnt_ff[ch] + 16'h0001) & wmask_v[ch];
            end
          end
          TCMC_MD_ONECOUNT: begin
            if (trig_v[ch] && lowb) begin
              nxt_cnt[ch]  = reload;
              nxt_tint[ch] = 1'b1;
            end else if (tick_v[ch]) begin
              if (cnt_ff[ch] == 16'h0000) begin
                nxt_run[ch]  = 1'b0;
                nxt_tint[ch] = 1'b1;
              end else begin
                nxt_cnt[ch] = (cnt_ff[ch] - 16'h0001) & wmask_v[ch];
              end
            end
          end
          TCMC_MD_CAPONE: begin
            // A second trigger ends the width measurement, never restarts.
            if (trig_v[ch]) begin
              nxt_data[ch] = cnt_ff[ch];
              nxt_run[ch]  = 1'b0;
              nxt_tint[ch] = 1'b1;
            end else if (tick_v[ch]) begin
              nxt_cnt[ch] = (cnt_ff[ch] + 16'h0001) & wmask_v[ch];
            end
          end
          default: begin
            nxt_run[ch] = 1'b0;
          end
        endcase
      end
      ev_set[ch] = nxt_tint[ch];
      nxt_tout[ch] = tout_ff[ch] ^ nxt_tint[ch];
    end
    // A new event beats a write-one clear of the same bit.
    nxt_sts = sts_ff | ev_set;
    if (bus_in.wr && bus_in.addr == `TCMC_OFF_IRQ_STS) begin
      nxt_sts = (sts_ff & ~bus_in.wdata[3:0]) | ev_set;
    end
    nxt_irq = |(nxt_sts & nxt_mask);
    nxt_rdata = 16'h0000;
    if (bus_in.rd) begin
      if (bus_in.addr == `TCMC_OFF_MODE0) begin
        nxt_rdata = mode_ff[0];
      end else if (bus_in.addr == `TCMC_OFF_MODE3) begin
        nxt_rdata = mode_ff[1];
      end else if (bus_in.addr == `TCMC_OFF_DATA0) begin
        nxt_rdata = data_ff[0];
      end else if (bus_in.addr == `TCMC_OFF_DATA3) begin
        nxt_rdata = data_ff[1];
      end else if (bus_in.addr == `TCMC_OFF_IRQ_STS) begin
        nxt_rdata = {12'h000, sts_ff};
      end else if (bus_in.addr == `TCMC_OFF_IRQ_MASK) begin
        nxt_rdata = {12'h000, mask_ff};
      end else if (bus_in.addr == `TCMC_OFF_START) begin
        nxt_rdata = {14'h0000, run_ff};
      end else if (bus_in.addr == `TCMC_OFF_CNT0) begin
        nxt_rdata = cnt_ff[0];
      end else if (bus_in.addr == `TCMC_OFF_CNT3) begin
        nxt_rdata = cnt_ff[1];
      end
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_ff  <= '{`TCMC_MODE_RESET, `TCMC_MODE_RESET};
      data_ff  <= '{`TCMC_DATA_RESET, `TCMC_DATA_RESET};
      cnt_ff   <= '{16'h0000, 16'h0000};
      run_ff   <= 2'h0;
      tout_ff  <= 2'h0;
      tint_ff  <= 2'h0;
      sts_ff   <= 4'h0;
      mask_ff  <= 4'h0;
      rdata_ff <= 16'h0000;
      irq_ff   <= 1'b0;
    end else begin
      mode_ff  <= nxt_mode;
      data_ff  <= nxt_data;
      cnt_ff   <= nxt_cnt;
      run_ff   <= nxt_run;
      tout_ff  <= nxt_tout;
      tint_ff  <= nxt_tint;
      sts_ff   <= nxt_sts;
      mask_ff  <= nxt_mask;
      rdata_ff <= nxt_rdata;
      irq_ff   <= nxt_irq;
    end
  end

  assign rdata_out         = rdata_ff;
  assign timer_out_ch0_out = tout_ff[0];
  assign timer_out_ch3_out = tout_ff[1];
  assign tint_ch0_out      = tint_ff[0];
  assign tint_ch3_out      = tint_ff[1];
  assign irq_out           = irq_ff;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_sw_only_start: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) (mode_ff[0][10:8] == 3'h0 && !sw_start[0] &&
    !run_ff[0] && !(bus_in.wr && bus_in.addr == `TCMC_OFF_MODE0))
    |=> !run_ff[0]) else $error("channel 0 started without software");

  a_edge_start: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) (mode_ff[0][10:8] == 3'h1 && vedge_v[0] &&
    !run_ff[0] && !bad_v[0] && !sw_stop[0]) |=> run_ff[0])
    else $error("valid pin edge did not start channel 0");

  a_both_edges: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) (mode_ff[1][10:8] == 3'h2 && fall_v[1] &&
    !run_ff[1] && !bad_v[1] && !sw_stop[1]) |=> run_ff[1])
    else $error("falling pin edge did not start channel 3");

  a_master_trig: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) (mode_ff[1][10:8] == 3'h4 && master_int_in &&
    !run_ff[1] && !bad_v[1] && !sw_stop[1]) |=> run_ff[1])
    else $error("master interrupt did not start channel 3");

  a_interval_down: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) (run_ff[0] && md_v[0] == TCMC_MD_INTERVAL &&
    tick_v[0] && cnt_ff[0] != 16'h0000 && !bad_v[0] && !sw_stop[0])
    |=> cnt_ff[0] == $past(cnt_ff[0]) - 16'h0001)
    else $error("interval counter did not count down");

  a_capture_up: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) (run_ff[0] && md_v[0] == TCMC_MD_CAPTURE &&
    tick_v[0] && !trig_v[0] && !bad_v[0] && !sw_stop[0])
    |=> cnt_ff[0] == $past(cnt_ff[0]) + 16'h0001)
    else $error("capture counter did not count up");

  a_start_int: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) (!run_ff[0] && trig_v[0] && !bad_v[0] &&
    !sw_stop[0] && md_v[0] == TCMC_MD_INTERVAL && mode_ff[0][0])
    |=> tint_ch0_out && (timer_out_ch0_out != $past(timer_out_ch0_out)))
    else $error("no start interrupt with low mode bit set");

  a_no_start_int: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) (!run_ff[0] && trig_v[0] && !mode_ff[0][0])
    |=> !tint_ch0_out && $stable(timer_out_ch0_out))
    else $error("start interrupt with low mode bit clear");

  a_onecount_ignore: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) (run_ff[0] && md_v[0] == TCMC_MD_ONECOUNT &&
    !mode_ff[0][0] && trig_v[0] && !tick_v[0]) |=> $stable(cnt_ff[0]) &&
    !tint_ch0_out) else $error("one-count accepted a retrigger");

  a_onecount_restart: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) (run_ff[0] && md_v[0] == TCMC_MD_ONECOUNT &&
    mode_ff[0][0] && trig_v[0] && !bad_v[0] && !sw_stop[0])
    |=> tint_ch0_out && cnt_ff[0] == $past(data_ff[0]))
    else $error("one-count did not restart on trigger");

  a_split_byte: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) mode_ff[1][11] && $past(mode_ff[1][11]) &&
    run_ff[1] && $past(run_ff[1]) |-> cnt_ff[1][15:8] == 8'h00)
    else $error("split channel 3 used its upper byte");

  a_mode_zeros: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) bus_in.rd && bus_in.addr == `TCMC_OFF_MODE0
    |=> rdata_out[13] == 1'b0 && rdata_out[11] == 1'b0 &&
    rdata_out[5:4] == 2'h0) else $error("mode reserved bits not zero");

endmodule : tcmc_timer_mode

// >>> testbench.sv
`include "tcmc_params.svh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import tcmc_pkg::*;

  logic                  sys_clk_in;
  logic                  nrst_in;
  tcmc_bus_type          bus;
  logic [15:0]           rdata;
  logic [3:0]            ck;
  logic                  pin0, pin3, mst;
  logic                  tout0, tout3, tint0, tint3, irq;
  int                    error_cnt;
  int                    checks;
  int                    tints = 0;

  tcmc_timer_mode i_tcmc_timer_mode (
    .sys_clk_in          (sys_clk_in),
    .nrst_in             (nrst_in),
    .bus_in              (bus),
    .rdata_out           (rdata),
    .prescaled_clk_in    (ck),
    .timer_in_pin_ch0_in (pin0),
    .timer_in_pin_ch3_in (pin3),
    .master_int_in       (mst),
    .timer_out_ch0_out   (tout0),
    .timer_out_ch3_out   (tout3),
    .tint_ch0_out        (tint0),
    .tint_ch3_out        (tint3),
    .irq_out             (irq)
  );

  tcmc_far_side i_tcmc_far_side (
    .sys_clk_in     (sys_clk_in),
    .pin_ch0_out    (pin0),
    .pin_ch3_out    (pin3),
    .master_int_out (mst)
  );

  // ------------------------------------------------------------------
  // Clock, pulse counter and tasks
  // ------------------------------------------------------------------
  initial sys_clk_in = 1'b0;
  always #2.5 sys_clk_in = ~sys_clk_in;

  // Pulses are counted as they pass, so no pulse is missed by a read.
  always @(posedge sys_clk_in) begin
    if (tint0 === 1'b1) tints <= tints + 1;
  end

  task automatic complete_run();
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_in);
    bus <= '0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk_in);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_in);
    bus <= '0;
    #1;
    chk(rdata, exp);
  endtask : rd

  task automatic tick(input logic [3:0] m);
    @(posedge sys_clk_in);
    ck <= m;
    @(posedge sys_clk_in);
    ck <= 4'h0;
  endtask : tick

  // Stop first: a mode change while counting is not a supported use.
  task automatic setup0(input logic [15:0] md, input logic [15:0] d);
    wr(`TCMC_OFF_STOP, 16'h0003);
    wr(`TCMC_OFF_MODE0, md);
    wr(`TCMC_OFF_DATA0, d);
    wr(`TCMC_OFF_IRQ_STS, 16'h000f);
  endtask : setup0

  initial begin
    repeat (40000) @(posedge sys_clk_in);
    error_cnt++;
    complete_run();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    bus = '0;
    ck = 4'h0;
    nrst_in = 1'b0;
    error_cnt = 0;
    checks = 0;
    repeat (10) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    rd(`TCMC_OFF_MODE0, 16'h0000);
    rd(`TCMC_OFF_DATA0, 16'hffff);
    rd(8'h30, 16'h0000);
    wr(`TCMC_OFF_MODE0, 16'hffff);
    rd(`TCMC_OFF_MODE0, 16'hd7cf);
    wr(`TCMC_OFF_MODE3, 16'hffff);
    rd(`TCMC_OFF_MODE3, 16'hdfcf);
    rd(`TCMC_OFF_IRQ_STS, 16'h000c);
    wr(`TCMC_OFF_MODE3, 16'h0800);
    wr(`TCMC_OFF_DATA3, 16'h1234);
    wr(`TCMC_OFF_START, 16'h0002);
    rd(`TCMC_OFF_CNT3, 16'h0034);
    wr(`TCMC_OFF_STOP, 16'h0002);
    wr(`TCMC_OFF_MODE3, 16'h0c01);
    i_tcmc_far_side.pulse_master();
    #1;
    chk({15'h0000, tint3}, 16'h0001);
    chk({15'h0000, tout3}, 16'h0001);
    rd(`TCMC_OFF_START, 16'h0002);
    i_tcmc_far_side.set_pin(1'b1, 1'b1);
    wr(`TCMC_OFF_STOP, 16'h0002);
    wr(`TCMC_OFF_MODE3, 16'h0a00);
    i_tcmc_far_side.set_pin(1'b1, 1'b0);
    rd(`TCMC_OFF_START, 16'h0002);
    rd(`TCMC_OFF_IRQ_STS, 16'h000e);
    setup0(16'h0000, 16'h0002);
    wr(`TCMC_OFF_START, 16'h0001);
    rd(`TCMC_OFF_IRQ_STS, 16'h0000);
    rd(`TCMC_OFF_CNT0, 16'h0002);
    tick(4'h1);
    rd(`TCMC_OFF_CNT0, 16'h0001);
    tick(4'h1);
    tick(4'h1);
    rd(`TCMC_OFF_CNT0, 16'h0002);
    rd(`TCMC_OFF_IRQ_STS, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    wr(`TCMC_OFF_IRQ_MASK, 16'h0001);
    @(posedge sys_clk_in);
    #1;
    chk({15'h0000, irq}, 16'h0001);
    wr(`TCMC_OFF_IRQ_STS, 16'h0001);
    @(posedge sys_clk_in);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    setup0(16'h0001, 16'h0002);
    wr(`TCMC_OFF_START, 16'h0001);
    rd(`TCMC_OFF_IRQ_STS, 16'h0001);
    chk(16'(tints), 16'h0002);
    chk({15'h0000, tout0}, 16'h0000);
    setup0(16'h0144, 16'h0000);
    wr(`TCMC_OFF_START, 16'h0001);
    tick(4'h1);
    tick(4'h1);
    rd(`TCMC_OFF_CNT0, 16'h0002);
    i_tcmc_far_side.set_pin(1'b0, 1'b1);
    rd(`TCMC_OFF_DATA0, 16'h0002);
    rd(`TCMC_OFF_IRQ_STS, 16'h0001);
    tick(4'h1);
    i_tcmc_far_side.set_pin(1'b0, 1'b0);
    rd(`TCMC_OFF_DATA0, 16'h0002);
    setup0(16'h0204, 16'h0000);
    wr(`TCMC_OFF_START, 16'h0001);
    tick(4'h1);
    i_tcmc_far_side.set_pin(1'b0, 1'b1);
    rd(`TCMC_OFF_DATA0, 16'h0001);
    tick(4'h1);
    tick(4'h1);
    i_tcmc_far_side.set_pin(1'b0, 1'b0);
    rd(`TCMC_OFF_DATA0, 16'h0002);
    setup0(16'h0000, 16'h0005);
    i_tcmc_far_side.set_pin(1'b0, 1'b1);
    i_tcmc_far_side.set_pin(1'b0, 1'b0);
    rd(`TCMC_OFF_START, 16'h0000);
    setup0(16'h0100, 16'h0005);
    i_tcmc_far_side.set_pin(1'b0, 1'b1);
    rd(`TCMC_OFF_START, 16'h0000);
    i_tcmc_far_side.set_pin(1'b0, 1'b0);
    rd(`TCMC_OFF_START, 16'h0001);
    setup0(16'h0408, 16'h0003);
    i_tcmc_far_side.pulse_master();
    rd(`TCMC_OFF_START, 16'h0001);
    tick(4'h1);
    i_tcmc_far_side.pulse_master();
    rd(`TCMC_OFF_CNT0, 16'h0002);
    rd(`TCMC_OFF_IRQ_STS, 16'h0000);
    repeat (3) tick(4'h1);
    rd(`TCMC_OFF_START, 16'h0000);
    rd(`TCMC_OFF_IRQ_STS, 16'h0001);
    setup0(16'h0409, 16'h0003);
    i_tcmc_far_side.pulse_master();
    tick(4'h1);
    wr(`TCMC_OFF_IRQ_STS, 16'h000f);
    i_tcmc_far_side.pulse_master();
    rd(`TCMC_OFF_CNT0, 16'h0003);
    rd(`TCMC_OFF_IRQ_STS, 16'h0001);
    setup0(16'h1046, 16'h0005);
    wr(`TCMC_OFF_START, 16'h0001);
    tick(4'hf);
    rd(`TCMC_OFF_CNT0, 16'h0005);
    i_tcmc_far_side.set_pin(1'b0, 1'b1);
    i_tcmc_far_side.set_pin(1'b0, 1'b0);
    rd(`TCMC_OFF_CNT0, 16'h0004);
    setup0(16'h014c, 16'h0000);
    wr(`TCMC_OFF_START, 16'h0001);
    rd(`TCMC_OFF_IRQ_STS, 16'h0000);
    repeat (3) tick(4'h1);
    i_tcmc_far_side.set_pin(1'b0, 1'b1);
    rd(`TCMC_OFF_DATA0, 16'h0003);
    rd(`TCMC_OFF_START, 16'h0000);
    i_tcmc_far_side.set_pin(1'b0, 1'b0);
    for (int s = 0; s < 4; s++) begin
      setup0({s[1:0], 14'h0000}, 16'h0009);
      wr(`TCMC_OFF_START, 16'h0001);
      tick(~(4'h1 << {s[0], s[1]}));
      rd(`TCMC_OFF_CNT0, 16'h0009);
      tick(4'h1 << {s[0], s[1]});
      rd(`TCMC_OFF_CNT0, 16'h0008);
    end
    setup0(16'h000e, 16'h0001);
    wr(`TCMC_OFF_START, 16'h0001);
    rd(`TCMC_OFF_START, 16'h0000);
    rd(`TCMC_OFF_IRQ_STS, 16'h0004);
    setup0(16'h0300, 16'h0001);
    rd(`TCMC_OFF_IRQ_STS, 16'h0004);
    complete_run();
  end
endmodule : testbench
